// >>> rtl/quhb_chan_decode.sv
`timescale 1ns/1ps
`default_nettype none

module quhb_chan_decode (
  input  wire logic       busStyleSel,  // High: per-channel select style.
  input  wire logic [3:0] selPins_n,    // Select pins A..D as sampled.
  output logic [1:0]      chanIdx,      // Channel reached by the access.
  output logic            chanHit,      // An access is selected.
  output logic            selConflict   // Strap high: more than one channel select low.
);

  logic [2:0] lowCount;

  always_comb begin
    lowCount = 3'h0;
    for (int i = 0; i < quhb_pkg::NUM_CHAN; i++) begin
      lowCount = lowCount + {2'h0, ~selPins_n[i]};
    end
    chanIdx     = 2'h0;
    chanHit     = 1'b0;
    selConflict = 1'b0;
    if (busStyleSel) begin
      selConflict = (lowCount > 3'h1);
      chanHit     = (lowCount == 3'h1);
      for (int i = 0; i < quhb_pkg::NUM_CHAN; i++) begin
        if (!selPins_n[i]) begin
          chanIdx = 2'(i);
        end
      end
    end else begin
      // The last select pin is ignored here; the host keeps it high.
      chanHit = ~selPins_n[0];
      chanIdx = {selPins_n[2], selPins_n[1]};
    end
  end

endmodule

`default_nettype wire

// >>> rtl/quhb_host_port.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RQ1] Strap high: write strobe rise commits byte.
// [RQ2] Strap low: write pin is read/write direction.
// [RQ3] Strap high: four selects, one per channel.
// [RQ4] Strap low: select A is device select.
// [RQ5] Strap low: selects B, C are channel bits.
// [RQ6] Strap low: host holds select D high.
// [RQ7] Strap high: pin A follows channel A drive bit.
// [RQ8] Strap high: pins B-D follow own drive bits.
// [RQ9] Strap low: pin A is open-drain device interrupt.
// [RQ10] Strap low: pins B-D held at zero.
// [RQ11] Strap high, force high: all pins driven.
// [RQ12] Force low: drive bit alone decides driving.
// [RQ13] Host keeps force low in strap-low style.
// [RQ14] Force input active high, inactive when open.
// [RQ15] Three address lines pick one of eight registers.
// [RQ16] Strap high: read strobe low drives addressed byte.
// [RQ17] Channel bits decode 00 A to 11 D.
// [RQ18] Host asserts at most one channel select.

module quhb_host_port #(
  parameter int APB_AW = 8                    // APB address width.
) (
  input  wire logic              clk_sys,          // 125 MHz clock.
  input  wire logic              rstn,             // Async reset, low.
  input  wire logic              psel,             // APB select.
  input  wire logic              penable,          // APB enable.
  input  wire logic              pwrite,           // APB direction.
  input  wire logic [APB_AW-1:0] paddr,            // APB byte address.
  input  wire logic [31:0]       pwdata,           // APB write data.
  output logic                   pready,           // APB ready.
  output logic      [31:0]       prdata,           // APB read data.
  output logic                   pslverr,          // APB error.
  output logic                   irq,              // Level interrupt.
  input  wire logic              busStyleSel,      // Bus style strap.
  input  wire logic              write_strobe_n,   // Write strobe or R/W.
  input  wire logic              read_strobe_n,    // Read strobe.
  input  wire logic              chan_select_a_n,  // Select A or device.
  input  wire logic              chan_select_b_n,  // Select B or A3.
  input  wire logic              chan_select_c_n,  // Select C or A4.
  input  wire logic              chan_select_d_n,  // Select D; unused when strap low.
  input  wire logic [2:0]        hostAddr,         // Register address.
  input  wire logic [7:0]        hostDataIn,       // Data bus input.
  output logic      [7:0]        hostDataOut,      // Data bus output.
  output logic                   hostDataOe_n,     // Data enable, low.
  input  wire logic              irq_force_drive,  // Interrupt force.
  output wire logic              irq_out_a,        // Interrupt pin A.
  output wire logic              irq_out_a_oe_n,   // Pin A enable, low.
  output wire logic              irq_out_b,        // Interrupt pin B.
  output wire logic              irq_out_b_oe_n,   // Pin B enable, low.
  output wire logic              irq_out_c,        // Interrupt pin C.
  output wire logic              irq_out_c_oe_n,   // Pin C enable, low.
  output wire logic              irq_out_d,        // Interrupt pin D.
  output wire logic              irq_out_d_oe_n    // Pin D enable, low.
);

  if (APB_AW < quhb_pkg::APB_AW_MIN) begin : g_chk
    $error("APB_AW too small for the register map.");
  end

  localparam int NIDX = quhb_pkg::NUM_CHAN * quhb_pkg::NUM_REG;

  quhb_pkg::quhb_state_type            state_reg;
  quhb_pkg::quhb_state_type            state_next;
  logic [7:0]                          hostReg [NIDX];
  logic [quhb_pkg::IDX_W-1:0]          accIdx_reg;
  logic [7:0]                          wrData_reg;
  logic [quhb_pkg::ST_W-1:0]           status_reg;
  logic [quhb_pkg::ST_W-1:0]           status_next;
  logic [quhb_pkg::ST_W-1:0]           mask_reg;
  logic [3:0]                          irqSrc_reg;
  logic [quhb_pkg::LAST_W-1:0]         last_reg;
  logic [3:0]                          mcrDrive;
  logic [1:0]                          chanIdx;
  logic                                chanHit;
  logic                                selConflict;
  logic                                rdReq;
  logic                                wrReq;
  logic                                commitWr;
  logic                                startRd;
  logic                                evConflict;
  logic                                apbAccess;
  logic                                statusClr;
  logic [3:0]                          irqVal;
  logic [3:0]                          irqOe_n;

  // ---------------------------------------------------------------
  // Channel decode and host request terms
  // ---------------------------------------------------------------
  quhb_chan_decode u_decode (
    .busStyleSel (busStyleSel),
    .selPins_n   ({chan_select_d_n, chan_select_c_n,
                   chan_select_b_n, chan_select_a_n}),
    .chanIdx     (chanIdx),
    .chanHit     (chanHit),
    .selConflict (selConflict)
  ); // RQ3 RQ4 RQ5 RQ17

  // The write pin is a strobe in one style and a direction line in the
  // other; a low level asks for a write in both.
  assign wrReq = chanHit & ~write_strobe_n; // RQ1 RQ2
  assign rdReq = chanHit & (busStyleSel ? ~read_strobe_n
                                        : write_strobe_n); // RQ2 RQ16
  assign evConflict = selConflict & (~write_strobe_n | ~read_strobe_n);

  // ---------------------------------------------------------------
  // Host access sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    commitWr   = 1'b0;
    startRd    = 1'b0;
    unique case (state_reg)
      quhb_pkg::HS_IDLE: begin
        if (busStyleSel && rdReq) begin
          state_next = quhb_pkg::HS_READ;
          startRd    = 1'b1;
        end else if (wrReq) begin
          state_next = quhb_pkg::HS_WRITE;
        end else if (rdReq) begin
          state_next = quhb_pkg::HS_READ;
          startRd    = 1'b1;
        end
      end
      quhb_pkg::HS_READ: begin
        if (!rdReq) begin
          state_next = quhb_pkg::HS_IDLE;
        end
      end
      quhb_pkg::HS_WRITE: begin
        if (!wrReq) begin
          state_next = quhb_pkg::HS_IDLE;
          // Strap high: a lost select aborts and only the strobe rise commits; strap low: select A rise commits, a direction change aborts.
          commitWr   = busStyleSel ? write_strobe_n
                                   : chan_select_a_n; // RQ1 RQ2
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= quhb_pkg::HS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address is taken at the start of a read and followed while a write
  // strobe stays low, so the byte lands where the lines point at the end.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      accIdx_reg <= '0;
      wrData_reg <= quhb_pkg::HOST_REG_RST;
    end else if (startRd || state_next == quhb_pkg::HS_WRITE) begin
      accIdx_reg <= {chanIdx, hostAddr}; // RQ15
      wrData_reg <= hostDataIn;
    end
  end

  // ---------------------------------------------------------------
  // Channel register storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NIDX; i++) begin
        hostReg[i] <= quhb_pkg::HOST_REG_RST;
      end
    end else if (commitWr) begin
      hostReg[accIdx_reg] <= wrData_reg; // RQ1 RQ15
    end
  end

  for (genvar c = 0; c < quhb_pkg::NUM_CHAN; c++) begin : g_mcr
    assign mcrDrive[c] =
      hostReg[{2'(c), quhb_pkg::MODEM_CTRL_IDX}][quhb_pkg::MODEM_DRV_BIT];
  end

  // Bus is only driven once the read has stood a full cycle, which keeps
  // the data stable for the whole time the enable is low.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hostDataOut  <= quhb_pkg::HOST_REG_RST;
      hostDataOe_n <= 1'b1;
    end else begin
      hostDataOut  <= hostReg[accIdx_reg];
      hostDataOe_n <= ~(state_reg == quhb_pkg::HS_READ &&
                        state_next == quhb_pkg::HS_READ); // RQ16
    end
  end

  // ---------------------------------------------------------------
  // Interrupt pins
  // ---------------------------------------------------------------
  // The force input has no pull inside the core; an open pin must be
  // tied low at the pad, so a floating input is read as inactive.
  quhb_irq_pins u_irq (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .busStyleSel (busStyleSel),
    .forceDrive  (irq_force_drive), // RQ14
    .mcrDrive    (mcrDrive),
    .chanIrq     (irqSrc_reg),
    .irqVal      (irqVal),
    .irqOe_n     (irqOe_n)
  );

  assign irq_out_a      = irqVal[0];
  assign irq_out_a_oe_n = irqOe_n[0];
  assign irq_out_b      = irqVal[1];
  assign irq_out_b_oe_n = irqOe_n[1];
  assign irq_out_c      = irqVal[2];
  assign irq_out_c_oe_n = irqOe_n[2];
  assign irq_out_d      = irqVal[3];
  assign irq_out_d_oe_n = irqOe_n[3];

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign apbAccess = psel & penable & ~pready;
  assign statusClr = apbAccess & ~pwrite &
                     (paddr == APB_AW'(quhb_pkg::OFS_STATUS));

  always_comb begin
    status_next = status_reg;
    if (statusClr) begin
      status_next = '0;
    end
    // Set wins over the read clear in the same cycle.
    status_next[quhb_pkg::ST_WRITE]    = status_next[quhb_pkg::ST_WRITE]
                                         | commitWr;
    status_next[quhb_pkg::ST_READ]     = status_next[quhb_pkg::ST_READ]
                                         | startRd;
    status_next[quhb_pkg::ST_CONFLICT] = status_next[quhb_pkg::ST_CONFLICT]
                                         | evConflict;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_reg <= quhb_pkg::STATUS_RST;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq        <= |(status_next & mask_reg);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_reg <= quhb_pkg::LAST_RST;
    end else if (commitWr || startRd) begin
      last_reg <= {commitWr, accIdx_reg,
                   commitWr ? wrData_reg : 8'h00};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready     <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
      mask_reg   <= quhb_pkg::MASK_RST;
      irqSrc_reg <= quhb_pkg::IRQ_SRC_RST;
    end else begin
      pready  <= apbAccess;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (apbAccess) begin
        if (paddr == APB_AW'(quhb_pkg::OFS_STATUS)) begin
          prdata <= 32'(status_reg);
        end else if (paddr == APB_AW'(quhb_pkg::OFS_MASK)) begin
          prdata <= 32'(mask_reg);
          if (pwrite) begin
            mask_reg <= pwdata[quhb_pkg::ST_W-1:0];
          end
        end else if (paddr == APB_AW'(quhb_pkg::OFS_IRQ_SRC)) begin
          prdata <= 32'(irqSrc_reg);
          if (pwrite) begin
            irqSrc_reg <= pwdata[3:0];
          end
        end else if (paddr == APB_AW'(quhb_pkg::OFS_LAST)) begin
          prdata <= 32'(last_reg);
        end else if (paddr == APB_AW'(quhb_pkg::OFS_MCR_VIEW)) begin
          prdata <= 32'(mcrDrive);
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_wr_open;
    state_reg == quhb_pkg::HS_WRITE && busStyleSel && wrReq;
  endsequence
  sequence s_wr_close;
    busStyleSel && write_strobe_n && !evConflict;
  endsequence

  property p_strobe_commit;
    logic [quhb_pkg::IDX_W-1:0] ix;
    logic [7:0] d;
    (s_wr_open, ix = {chanIdx, hostAddr}, d = hostDataIn) ##1 s_wr_close
      |=> (hostReg[ix] == d) && status_reg[quhb_pkg::ST_WRITE];
  endproperty
  a_strobe_commit: assert property (p_strobe_commit) // RQ1
    else $error("Write strobe rise did not commit the byte.");

  property p_dir_read;
    (!busStyleSel && !chan_select_a_n && write_strobe_n)[*3]
      |-> !hostDataOe_n;
  endproperty
  a_dir_read: assert property (p_dir_read) // RQ2
    else $error("Direction high with select did not drive the bus.");

  property p_read_data;
    !hostDataOe_n |-> hostDataOut == $past(hostReg[accIdx_reg]);
  endproperty
  a_read_data: assert property (p_read_data) // RQ16
    else $error("Driven byte is not the addressed register.");

  property p_no_drive_idle;
    (busStyleSel && read_strobe_n)[*2] |-> hostDataOe_n;
  endproperty
  a_no_drive_idle: assert property (p_no_drive_idle) // RQ16
    else $error("Data bus driven without a read strobe.");

  property p_moto_decode;
    !busStyleSel && startRd
      |=> accIdx_reg[quhb_pkg::IDX_W-1 -: 2] ==
          $past({chan_select_c_n, chan_select_b_n});
  endproperty
  a_moto_decode: assert property (p_moto_decode) // RQ17
    else $error("Channel bits decoded to the wrong channel.");

  property p_mcr_float;
    (busStyleSel && !irq_force_drive && !mcrDrive[0])[*2]
      |-> irq_out_a_oe_n;
  endproperty
  a_mcr_float: assert property (p_mcr_float) // RQ7
    else $error("Pin A driven with its drive bit clear.");

  property p_mcr_drive_d;
    (busStyleSel && mcrDrive[3])[*2]
      |-> !irq_out_d_oe_n && irq_out_d == $past(irqSrc_reg[3]);
  endproperty
  a_mcr_drive_d: assert property (p_mcr_drive_d) // RQ8 RQ12
    else $error("Pin D not driving its interrupt with drive bit set.");

  property p_force_all;
    (busStyleSel && irq_force_drive)[*2] |-> irqOe_n == 4'h0;
  endproperty
  a_force_all: assert property (p_force_all) // RQ11
    else $error("Force input did not enable every interrupt pin.");

  property p_open_drain;
    (!busStyleSel)[*2]
      |-> !irq_out_a && (irq_out_a_oe_n == !$past(|irqSrc_reg));
  endproperty
  a_open_drain: assert property (p_open_drain) // RQ9
    else $error("Shared interrupt pin not behaving as open drain.");

  // The pins take their mode values one edge after reset lets go, so the
  // strap must have stood for three samples before the check applies.
  property p_unused_zero;
    (!busStyleSel)[*3] |-> irqVal[3:1] == 3'h0 && irqOe_n[3:1] == 3'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) // RQ10
    else $error("Unused interrupt pins not held at zero.");

endmodule

`default_nettype wire

// >>> rtl/quhb_irq_pins.sv
`timescale 1ns/1ps
`default_nettype none

module quhb_irq_pins (
  input  wire logic       clk_sys,      // System clock.
  input  wire logic       rstn,         // Asynchronous reset, active low.
  input  wire logic       busStyleSel,  // High: per-channel select style.
  input  wire logic       forceDrive,   // Interrupt force input.
  input  wire logic [3:0] mcrDrive,     // Drive bit of each channel.
  input  wire logic [3:0] chanIrq,      // Interrupt level per channel.
  output logic      [3:0] irqVal,       // Pin output values.
  output logic      [3:0] irqOe_n       // Pin enables, low drives.
);

  // ---------------------------------------------------------------
  // Per-channel pin drivers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < quhb_pkg::NUM_CHAN; i++) begin : g_pin
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        irqVal[i]  <= 1'b0;
        irqOe_n[i] <= 1'b1;
      end else if (busStyleSel) begin
        irqVal[i]  <= chanIrq[i];
        irqOe_n[i] <= ~(forceDrive | mcrDrive[i]); // RQ7 RQ8 RQ11 RQ12
      end else if (i == 0) begin
        // Open drain: only ever pulls low, never drives high.
        irqVal[i]  <= 1'b0;
        irqOe_n[i] <= ~(|chanIrq); // RQ9
      end else begin
        irqVal[i]  <= 1'b0;
        irqOe_n[i] <= 1'b0; // RQ10
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/quhb_pkg.sv
package quhb_pkg;

  // ---------------------------------------------------------------
  // Host-side geometry
  // ---------------------------------------------------------------
  localparam int         NUM_CHAN     = 4;
  localparam int         NUM_REG      = 8;
  localparam int         CHAN_W       = 2;
  localparam int         HADDR_W      = 3;
  localparam int         IDX_W        = CHAN_W + HADDR_W;
  localparam logic [2:0] MODEM_CTRL_IDX = 3'h4;
  localparam int         MODEM_DRV_BIT  = 3;
  localparam logic [7:0] HOST_REG_RST   = 8'h00;

  // ---------------------------------------------------------------
  // APB register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int         APB_AW_MIN   = 5;
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_MASK     = 8'h04;
  localparam logic [7:0] OFS_IRQ_SRC  = 8'h08;
  localparam logic [7:0] OFS_LAST     = 8'h0C;
  localparam logic [7:0] OFS_MCR_VIEW = 8'h10;

  // Status and mask bit positions.
  localparam int         ST_WRITE     = 0;
  localparam int         ST_READ      = 1;
  localparam int         ST_CONFLICT  = 2;
  localparam int         ST_W         = 3;
  localparam logic [2:0] STATUS_RST   = 3'h0;
  localparam logic [2:0] MASK_RST     = 3'h0;
  localparam logic [3:0] IRQ_SRC_RST  = 4'h0;

  // Fields of the last-access register.
  localparam int         LAST_DATA_LSB = 0;
  localparam int         LAST_ADDR_LSB = 8;
  localparam int         LAST_CHAN_LSB = 11;
  localparam int         LAST_WR_BIT   = 13;
  localparam int         LAST_W        = 14;
  localparam logic [13:0] LAST_RST     = 14'h0000;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_READ  = 3'b010,
    HS_WRITE = 3'b100
  } quhb_state_type;

endpackage

// >>> verif/quhb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module quhb_host_model (
  input  wire logic       clk_sys,   // System clock.
  input  wire logic       style,     // Bus style strap.
  input  wire logic [7:0] dataOut,   // Device data bus.
  input  wire logic       dataOe_n,  // Device bus enable, low.
  output logic            wrN,       // Write strobe or direction.
  output logic            rdN,       // Read strobe.
  output logic      [3:0] selN,      // Select pins A..D.
  output logic      [2:0] addr,      // Register address.
  output logic      [7:0] dIn        // Host data drive.
);
  logic tmo;

  initial begin
    wrN = 1'b1;
    rdN = 1'b1;
    selN = 4'hF;
    addr = 3'h0;
    dIn = 8'h00;
    tmo = 1'b0;
  end

  // On a read the host drives the inverse on its data lines and takes the byte from the device
  // output once the enable goes low; 20 cycles without it set the timeout flag.
  task automatic xfer(input logic w, input logic [1:0] ch,
                      input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    q = 8'h00;
    @(posedge clk_sys);
    addr <= a;
    dIn <= w ? d : ~d;
    if (style) begin
      selN <= ~(4'h1 << ch);
      if (w) wrN <= 1'b0;
      else rdN <= 1'b0;
    end else begin
      selN <= {1'b1, ch, 1'b0};
      wrN <= ~w;
    end
    if (w) begin
      repeat (2) @(posedge clk_sys);
      if (style) wrN <= 1'b1;
      else selN[0] <= 1'b1;
      @(posedge clk_sys);
    end else begin
      do begin
        @(posedge clk_sys);
        n++;
      end while (dataOe_n !== 1'b0 && n < 20);
      q = dataOut;
      if (n >= 20) tmo = 1'b1;
    end
    selN <= 4'hF;
    wrN <= 1'b1;
    rdN <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

// >>> verif/test_quhb_host_port.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errCount++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end

module test_quhb_host_port;
  logic clk_sys, rstn, psel, penable, pwrite, busStyleSel, forceDrv, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, q;
  wire logic pready, pslverr, irq, hOe_n, wrN, rdN;
  wire logic [31:0] prdata;
  wire logic [7:0] hOut, hIn;
  wire logic [3:0] selN, irqV, irqOe_n;
  wire logic [2:0] hAddr;
  logic [7:0] hq;
  int errCount, nTests;
  // Open-drain device interrupt: the board pull-up wins when released.
  wire logic pinA = irqOe_n[0] ? 1'b1 : irqV[0];

  quhb_host_port uut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .busStyleSel(busStyleSel), .write_strobe_n(wrN), .read_strobe_n(rdN),
    .chan_select_a_n(selN[0]), .chan_select_b_n(selN[1]),
    .chan_select_c_n(selN[2]), .chan_select_d_n(selN[3]),
    .hostAddr(hAddr), .hostDataIn(hIn), .hostDataOut(hOut),
    .hostDataOe_n(hOe_n), .irq_force_drive(forceDrv),
    .irq_out_a(irqV[0]), .irq_out_a_oe_n(irqOe_n[0]),
    .irq_out_b(irqV[1]), .irq_out_b_oe_n(irqOe_n[1]),
    .irq_out_c(irqV[2]), .irq_out_c_oe_n(irqOe_n[2]),
    .irq_out_d(irqV[3]), .irq_out_d_oe_n(irqOe_n[3]));

  quhb_host_model host (.clk_sys(clk_sys), .style(busStyleSel),
    .dataOut(hOut), .dataOe_n(hOe_n), .wrN(wrN), .rdN(rdN),
    .selN(selN), .addr(hAddr), .dIn(hIn));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic giveVerdict;
    if (errCount == 0 && nTests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errCount++;
      giveVerdict();
    end
  endtask

  task automatic hx(input logic w, input logic [1:0] ch,
                    input logic [2:0] a, input logic [7:0] d);
    host.xfer(w, ch, a, d, hq);
    if (host.tmo) begin
      errCount++;
      giveVerdict();
    end
  endtask

  task automatic doReset(input logic s);
    rstn <= 1'b0;
    busStyleSel <= s;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  initial begin
    {rstn, psel, penable, pwrite, forceDrv} = 5'b00000;
    {busStyleSel, paddr, pwdata} = 41'h1_0000_0000_00;
    errCount = 0;
    nTests = 0;
    doReset(1'b1);
    `CHK(irqOe_n, 4'hF)
    for (int c = 0; c < 4; c++) begin
      hx(1'b1, c[1:0], 3'd4, c[0] ? 8'h00 : 8'h08);
      hx(1'b1, c[1:0], 3'd2, 8'hA0 + c[7:0]);
    end
    for (int c = 0; c < 4; c++) begin
      hx(1'b0, c[1:0], 3'd2, 8'h00);
      `CHK(hq, 8'hA0 + c[7:0])
    end
    apb(1'b0, quhb_pkg::OFS_MCR_VIEW, 32'h0);
    `CHK(q, 32'h0000_0005)
    `CHK(irqOe_n, 4'b1010)
    apb(1'b1, quhb_pkg::OFS_IRQ_SRC, 32'h0000_0003);
    repeat (2) @(posedge clk_sys);
    `CHK(irqV, 4'b0011)
    `CHK(irq, 1'b0)
    forceDrv <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(irqOe_n, 4'h0)
    forceDrv <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(irqOe_n, 4'b1010)
    hx(1'b1, 2'd3, 3'd4, 8'h08);
    `CHK(irqOe_n, 4'b0010)
    apb(1'b0, quhb_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, quhb_pkg::OFS_MASK, 32'h0000_0004);
    host.selN <= 4'b1100;
    host.wrN <= 1'b0;
    host.dIn <= 8'h5A;
    repeat (2) @(posedge clk_sys);
    host.wrN <= 1'b1;
    @(posedge clk_sys);
    host.selN <= 4'hF;
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    apb(1'b0, quhb_pkg::OFS_STATUS, 32'h0);
    `CHK(q, 32'h0000_0004)
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    hx(1'b0, 2'd0, 3'd2, 8'h00);
    `CHK(hq, 8'hA0)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(perr, 1'b1)
    doReset(1'b0);
    `CHK(irqOe_n[3:1], 3'b000)
    `CHK(irqV[3:1], 3'b000)
    `CHK(pinA, 1'b1)
    for (int c = 0; c < 4; c++) hx(1'b1, c[1:0], 3'd3, 8'h50 + c[7:0]);
    apb(1'b0, quhb_pkg::OFS_LAST, 32'h0);
    `CHK(q, {18'h0, 1'b1, 2'd3, 3'd3, 8'h53})
    for (int c = 0; c < 4; c++) begin
      hx(1'b0, c[1:0], 3'd3, 8'h00);
      `CHK(hq, 8'h50 + c[7:0])
    end
    apb(1'b1, quhb_pkg::OFS_IRQ_SRC, 32'h0000_0004);
    repeat (2) @(posedge clk_sys);
    `CHK(pinA, 1'b0)
    `CHK(irqV[0], 1'b0)
    giveVerdict();
  end
endmodule

`default_nettype wire
